// ---- shared/dtc_pkg.sv ----
// Constants, types and register map of the dual timer/counter.
// Assumes a single 50 MHz system clock and an 8-bit register port.
`default_nettype none

package dtc_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_HZ = 50_000_000;
	localparam int MC_CLOCKS = 6;
	localparam logic [2:0] MC_FIRST = 3'h0;
	localparam logic [2:0] MC_LAST = 3'(MC_CLOCKS - 1);

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'h87;
	localparam logic [7:0] ADDR_RUN = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
	localparam logic [7:0] ADDR_TL0 = 8'h8a;
	localparam logic [7:0] ADDR_TL1 = 8'h8b;
	localparam logic [7:0] ADDR_TH0 = 8'h8c;
	localparam logic [7:0] ADDR_TH1 = 8'h8d;
	localparam logic [7:0] ADDR_AUX = 8'h8e;

	// Field positions
	localparam int TM_T0_MODE_LSB = 0;
	localparam int TM_CT0 = 2;
	localparam int TM_GATE0 = 3;
	localparam int TM_T1_MODE_LSB = 4;
	localparam int RC_TR0 = 4;
	localparam int RC_TF0 = 5;
	localparam int RC_TR1 = 6;
	localparam int RC_TF1 = 7;
	localparam int PC_BAUD_DBL = 7;
	localparam int AX_TOG_EN = 0;
	localparam int AX_CT1 = 1;

	// Reset values and masks
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TIMER_MODE_CONTROL_WMASK = 8'h3f;
	localparam logic BIT_RESET = 1'b0;
	localparam logic TOG_RESET = 1'b1;
	localparam logic [2:0] SYNC_RESET = 3'h0;
	localparam logic [3:0] DIV16_RESET = 4'h0;
	localparam logic [3:0] DIV16_LAST = 4'hf;
	localparam logic [4:0] PRESC_LAST = 5'h1f;
	localparam logic [7:0] BYTE_MAX = 8'hff;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_SPLIT = 2'b11,
		MODE_RELOAD = 2'b10
	} dtc_mode_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dtc_bus_req_s;

	typedef struct packed {
		logic [7:0] tl;
		logic [7:0] th;
		logic ovf;
	} dtc_step_s;

endpackage

`default_nettype wire

// ---- src/dtc_pin_sampler.sv ----
// Synchroniser and once-per-machine-cycle sampler for one input pin.
// Assumes mc_tick is a one-cycle pulse every machine cycle.
`default_nettype none

module dtc_pin_sampler (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic mc_tick,
	output logic level,
	output logic fall_seen
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [2:0] sync;
		logic stable;
		logic smp;
		logic fall;
	} dtc_smp_s;

	dtc_smp_s q, d;

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		d = q;
		d.sync = {q.sync[1:0], pin};
		// Only the second and third stage decide, the first is metastable
		if (q.sync[1] == q.sync[2]) begin
			d.stable = q.sync[2];
		end
		if (mc_tick) begin
			d.smp = q.stable;
			d.fall = q.smp & ~q.stable; // see [RULE_04]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{sync: SYNC_RESET, stable: BIT_RESET, smp: BIT_RESET,
				fall: BIT_RESET};
		end else begin
			q <= d;
		end
	end

	assign level = q.stable;
	// Held for one whole machine cycle so the count lands in the next one
	assign fall_seen = q.fall; // see [RULE_05]

	// ==========================================================
	// Checks
	// ==========================================================
	a_fall_holds: assert property ( // see [RULE_05]
		@(posedge clk_sys) disable iff (!rst_n)
		(mc_tick && q.smp && !q.stable) |=> fall_seen [*6])
		else $error("fall not held for a machine cycle");

	a_fall_cause: assert property ( // see [RULE_04]
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(fall_seen) |-> $past(mc_tick) && $past(q.smp))
		else $error("fall seen without high then low sample");

endmodule

`default_nettype wire

// ---- src/dtc_baud_gen.sv ----
// Serial baud ticks derived from timer 1 overflow pulses.
// Assumes t1_ovf is a one-cycle pulse on the system clock.
`default_nettype none

module dtc_baud_gen (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic t1_ovf,
	input wire logic baud_double,
	output logic x16_tick,
	output logic bit_tick
);
	import dtc_pkg::*;

	typedef struct packed {
		logic half;
		logic [3:0] div16;
		logic x16;
		logic bit_t;
	} dtc_baud_s;

	dtc_baud_s q, d;

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		d = q;
		d.x16 = 1'b0;
		d.bit_t = 1'b0;
		if (t1_ovf) begin
			// Undoubled rate halves the overflows first: bit = ovf / 32
			if (baud_double || q.half) begin // see [RULE_10]
				d.x16 = 1'b1;
				d.half = 1'b0;
			end else begin
				d.half = 1'b1;
			end
		end
		if (q.x16) begin // see [RULE_11]
			d.div16 = q.div16 + 4'h1;
			d.bit_t = (q.div16 == DIV16_LAST);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{half: BIT_RESET, div16: DIV16_RESET, x16: BIT_RESET,
				bit_t: BIT_RESET};
		end else begin
			q <= d;
		end
	end

	assign x16_tick = q.x16;
	assign bit_tick = q.bit_t;

	// ==========================================================
	// Checks
	// ==========================================================
	a_double_rate: assert property ( // see [RULE_10]
		@(posedge clk_sys) disable iff (!rst_n)
		(t1_ovf && baud_double) |=> x16_tick)
		else $error("doubled baud missed an overflow");

	a_tick_cause: assert property ( // see [RULE_11]
		@(posedge clk_sys) disable iff (!rst_n)
		x16_tick |-> $past(t1_ovf))
		else $error("baud tick without timer 1 overflow");

endmodule

`default_nettype wire

// ---- src/dtc_timer_core.sv ----
// Dual 16-bit timer/counter with mode register and baud output.
// Assumes a register master with one-cycle strobes; read data valid
// in the cycle after the read strobe.
// How it works
// [RULE_01] Timer function counts one per machine cycle.
// [RULE_02] Two timers, each timer or event counter.
// [RULE_03] Timer 0 overflow may toggle its pin.
// [RULE_04] Count input sampled per machine cycle, falls count.
// [RULE_05] Count shows the cycle after the fall.
// [RULE_06] Source holds each level one machine cycle.
// [RULE_07] Mode bit 2 picks clock or pin source.
// [RULE_08] Two-bit mode field per timer in mode register.
// [RULE_09] Modes: 13-bit, 16-bit, 8-bit auto-reload.
// [RULE_10] Baud doubling bit resets clear, doubles rate.
// [RULE_11] Timer 1 overflow sets serial baud rate.
// [RULE_12] Gate makes timer 0 need interrupt pin high.
// [RULE_13] Mode 3 splits timer 0, stops timer 1.
//
// Added by the designer: the strobed register port.
`default_nettype none

module dtc_timer_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire dtc_pkg::dtc_bus_req_s bus_req,
	output logic [7:0] rd_data,
	input wire logic count_input_zero_in,
	output logic count_input_zero_out,
	output logic count_input_zero_oe,
	input wire logic count_input_one,
	input wire logic ext_irq_zero_pin,
	output logic overflow_flag_zero,
	output logic overflow_flag_one,
	output logic baud_x16_tick,
	output logic baud_bit_tick
);
	import dtc_pkg::*;

	typedef struct packed {
		logic [2:0] mc_cnt;
		logic [7:0] timer_mode_control;
		logic tr0;
		logic tr1;
		logic tf0;
		logic tf1;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic baud_dbl;
		logic tog_en;
		logic ct1;
		logic tog;
		logic [7:0] rdata;
	} dtc_core_s;

	dtc_core_s q, d;

	logic mc_tick;
	logic irq_level;
	logic [1:0] pin_fall;
	dtc_mode_e mode0, mode1;
	logic ct0, gate0, run0, run1, inc0, inc1, inc_th0;
	logic wr_any, ovf0, ovf1, ovf_th0, split0;
	dtc_step_s st0, st1;

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic wr_hit(input dtc_bus_req_s r,
		input logic [7:0] a);
		wr_hit = r.wr && (r.addr == a);
	endfunction

	// One increment of a timer in the given mode
	function automatic dtc_step_s timer_step(input dtc_mode_e m,
		input logic [7:0] tl, input logic [7:0] th, input logic inc);
		dtc_step_s s;
		s.tl = tl;
		s.th = th;
		s.ovf = 1'b0;
		if (inc) begin
			unique case (m)
				MODE_13BIT: begin // see [RULE_09]
					// Low five bits prescale, upper three bits are kept
					s.tl[4:0] = tl[4:0] + 5'h01;
					if (tl[4:0] == PRESC_LAST) begin
						s.th = th + 8'h01;
						s.ovf = (th == BYTE_MAX);
					end
				end
				MODE_16BIT: begin // see [RULE_09]
					s.tl = tl + 8'h01;
					if (tl == BYTE_MAX) begin
						s.th = th + 8'h01;
						s.ovf = (th == BYTE_MAX);
					end
				end
				MODE_RELOAD: begin // see [RULE_09]
					if (tl == BYTE_MAX) begin
						s.tl = th;
						s.ovf = 1'b1;
					end else begin
						s.tl = tl + 8'h01;
					end
				end
				MODE_SPLIT: begin // see [RULE_13]
					s.tl = tl + 8'h01;
					s.ovf = (tl == BYTE_MAX);
				end
			endcase
		end
		return s;
	endfunction

	// ==========================================================
	// Pin samplers: [0] timer 0 count pin, [1] timer 1 count pin
	// ==========================================================
	logic [1:0] pin_raw;
	assign pin_raw = {count_input_one, count_input_zero_in};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt_pin
			dtc_pin_sampler u_smp (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.pin(pin_raw[gi]),
				.mc_tick(mc_tick),
				.level(),
				.fall_seen(pin_fall[gi])
			);
		end
	endgenerate

	// Interrupt pin only feeds the gate, so its falls are unused
	dtc_pin_sampler u_irq_smp (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin(ext_irq_zero_pin),
		.mc_tick(mc_tick),
		.level(irq_level),
		.fall_seen()
	);

	// ==========================================================
	// Count enables
	// ==========================================================
	always_comb begin
		mc_tick = (q.mc_cnt == MC_LAST); // see [RULE_01]
		mode0 = dtc_mode_e'(q.timer_mode_control[TM_T0_MODE_LSB +: 2]); // see [RULE_08]
		mode1 = dtc_mode_e'(q.timer_mode_control[TM_T1_MODE_LSB +: 2]); // see [RULE_08]
		ct0 = q.timer_mode_control[TM_CT0];
		gate0 = q.timer_mode_control[TM_GATE0];
		split0 = (mode0 == MODE_SPLIT);
		wr_any = bus_req.wr;
		// Gate adds the interrupt pin to the run bit
		run0 = q.tr0 && (!gate0 || irq_level); // see [RULE_12]
		// While timer 0 is split, its high byte owns timer 1's run bit,
		// so timer 1 keeps running for the baud rate
		run1 = split0 ? 1'b1 : q.tr1;
		// Clock source or pin falls, per timer
		inc0 = mc_tick && run0 && (ct0 ? pin_fall[0] : 1'b1); // see [RULE_07]
		inc1 = mc_tick && run1 && (mode1 != MODE_SPLIT) // see [RULE_13]
			&& (q.ct1 ? pin_fall[1] : 1'b1); // see [RULE_02]
		inc_th0 = split0 && mc_tick && q.tr1; // see [RULE_13]
		st0 = timer_step(mode0, q.tl0, q.th0, inc0); // see [RULE_04]
		st1 = timer_step(mode1, q.tl1, q.th1, inc1);
		ovf_th0 = inc_th0 && (q.th0 == BYTE_MAX);
		ovf0 = st0.ovf;
		ovf1 = split0 ? ovf_th0 : st1.ovf;
	end

	// ==========================================================
	// Next state and register port
	// ==========================================================
	always_comb begin
		d = q;
		d.mc_cnt = mc_tick ? MC_FIRST : q.mc_cnt + 3'h1; // see [RULE_01]
		d.tl0 = st0.tl;
		d.th0 = st0.th;
		d.tl1 = st1.tl;
		d.th1 = st1.th;
		if (inc_th0) begin
			d.th0 = q.th0 + 8'h01;
		end
		if (ovf0 && q.tog_en) begin
			d.tog = ~q.tog; // see [RULE_03]
		end

		// Software writes take the byte over a same-cycle increment
		if (wr_hit(bus_req, ADDR_TIMER_MODE_CONTROL)) begin
			d.timer_mode_control = bus_req.wdata & TIMER_MODE_CONTROL_WMASK;
		end
		if (wr_hit(bus_req, ADDR_RUN)) begin
			d.tr0 = bus_req.wdata[RC_TR0];
			d.tr1 = bus_req.wdata[RC_TR1];
			d.tf0 = bus_req.wdata[RC_TF0];
			d.tf1 = bus_req.wdata[RC_TF1];
		end
		if (wr_hit(bus_req, ADDR_TL0)) begin
			d.tl0 = bus_req.wdata;
		end
		if (wr_hit(bus_req, ADDR_TH0)) begin
			d.th0 = bus_req.wdata;
		end
		if (wr_hit(bus_req, ADDR_TL1)) begin
			d.tl1 = bus_req.wdata;
		end
		if (wr_hit(bus_req, ADDR_TH1)) begin
			d.th1 = bus_req.wdata;
		end
		if (wr_hit(bus_req, ADDR_POWER_CONTROL_REG)) begin
			d.baud_dbl = bus_req.wdata[PC_BAUD_DBL]; // see [RULE_10]
		end
		if (wr_hit(bus_req, ADDR_AUX)) begin
			d.tog_en = bus_req.wdata[AX_TOG_EN];
			d.ct1 = bus_req.wdata[AX_CT1];
		end

		// Hardware set wins over a software clear in the same cycle
		if (ovf0) begin
			d.tf0 = 1'b1;
		end
		if (ovf1) begin
			d.tf1 = 1'b1;
		end

		d.rdata = REG_RESET;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ADDR_TIMER_MODE_CONTROL: d.rdata = q.timer_mode_control;
				ADDR_RUN: begin
					d.rdata[RC_TR0] = q.tr0;
					d.rdata[RC_TF0] = q.tf0;
					d.rdata[RC_TR1] = q.tr1;
					d.rdata[RC_TF1] = q.tf1;
				end
				ADDR_TL0: d.rdata = q.tl0;
				ADDR_TH0: d.rdata = q.th0;
				ADDR_TL1: d.rdata = q.tl1;
				ADDR_TH1: d.rdata = q.th1;
				ADDR_POWER_CONTROL_REG: d.rdata[PC_BAUD_DBL] = q.baud_dbl;
				ADDR_AUX: begin
					d.rdata[AX_TOG_EN] = q.tog_en;
					d.rdata[AX_CT1] = q.ct1;
				end
				default: d.rdata = REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{mc_cnt: MC_FIRST, timer_mode_control: REG_RESET, tr0: BIT_RESET,
				tr1: BIT_RESET, tf0: BIT_RESET, tf1: BIT_RESET,
				tl0: REG_RESET, th0: REG_RESET, tl1: REG_RESET,
				th1: REG_RESET, baud_dbl: BIT_RESET, tog_en: BIT_RESET,
				ct1: BIT_RESET, tog: TOG_RESET, rdata: REG_RESET};
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs and baud generator
	// ==========================================================
	assign rd_data = q.rdata;
	assign count_input_zero_out = q.tog;
	// Driving the pin makes it an output; counting from it then sees
	// our own toggles, which is a programming error left to software
	assign count_input_zero_oe = q.tog_en; // see [RULE_03]
	assign overflow_flag_zero = q.tf0;
	assign overflow_flag_one = q.tf1;

	dtc_baud_gen u_baud (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.t1_ovf(st1.ovf), // see [RULE_11]
		.baud_double(q.baud_dbl),
		.x16_tick(baud_x16_tick),
		.bit_tick(baud_bit_tick)
	);

	// ==========================================================
	// Checks
	// ==========================================================
	a_mc_period: assert property ( // see [RULE_01]
		@(posedge clk_sys) disable iff (!rst_n)
		mc_tick |=> !mc_tick [*5] ##1 mc_tick)
		else $error("machine cycle is not six clocks");

	a_timer_step: assert property ( // see [RULE_01]
		@(posedge clk_sys) disable iff (!rst_n)
		(mc_tick && q.tr0 && !gate0 && !ct0 && mode0 == MODE_16BIT
			&& !wr_any)
		|=> q.tl0 == 8'($past(q.tl0) + 8'h01))
		else $error("timer 0 did not step on machine cycle");

	a_hold_between: assert property ( // see [RULE_05]
		@(posedge clk_sys) disable iff (!rst_n)
		(!mc_tick && !wr_any) |=> $stable(q.tl0) && $stable(q.tl1))
		else $error("count moved between machine cycles");

	a_count_fall: assert property ( // see [RULE_04]
		@(posedge clk_sys) disable iff (!rst_n)
		(ct0 && !pin_fall[0] && !wr_any) |=> $stable(q.tl0))
		else $error("counter moved without a pin fall");

	a_gate_block: assert property ( // see [RULE_12]
		@(posedge clk_sys) disable iff (!rst_n)
		(gate0 && !irq_level && !wr_any) |=> $stable(q.tl0))
		else $error("gated timer 0 counted with pin low");

	a_pin_toggle: assert property ( // see [RULE_03]
		@(posedge clk_sys) disable iff (!rst_n)
		(ovf0 && q.tog_en && !wr_any)
		|=> count_input_zero_out != $past(count_input_zero_out)
			&& overflow_flag_zero)
		else $error("overflow did not toggle pin");

	a_reload_low: assert property ( // see [RULE_09]
		@(posedge clk_sys) disable iff (!rst_n)
		(inc0 && mode0 == MODE_RELOAD && q.tl0 == BYTE_MAX && !wr_any)
		|=> q.tl0 == $past(q.th0) && overflow_flag_zero)
		else $error("reload mode did not reload low byte");

	a_t1_stopped: assert property ( // see [RULE_13]
		@(posedge clk_sys) disable iff (!rst_n)
		(mode1 == MODE_SPLIT && !wr_any)
		|=> $stable(q.tl1) && $stable(q.th1))
		else $error("timer 1 ran in mode 3");

	a_mode_source: assert property ( // see [RULE_07]
		@(posedge clk_sys) disable iff (!rst_n)
		(mc_tick && run0 && ct0 && pin_fall[0] && mode0 == MODE_16BIT
			&& !wr_any)
		|=> q.tl0 == 8'($past(q.tl0) + 8'h01))
		else $error("counter function missed a pin fall");

endmodule

`default_nettype wire

// ---- verif/dtc_event_src.sv ----
// Event source for the count pins: a burst of falling edges.
// Assumes the bench pulses start for one cycle while busy is low.
`default_nettype none

module dtc_event_src (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] n_pulses,
	input wire logic [7:0] hold_clks,
	output logic pin,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Burst generator
	// ==========================================================
	logic [8:0] edges_q;
	logic [7:0] cnt_q;

	// Each level stays hold_clks+1 clocks; the burst ends high
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin <= 1'b1;
			busy <= 1'b0;
			edges_q <= 9'h000;
			cnt_q <= 8'h00;
		end else if (start && !busy) begin
			busy <= 1'b1;
			edges_q <= {n_pulses, 1'b0};
			cnt_q <= hold_clks;
		end else if (busy) begin
			if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end else if (edges_q == 9'h000) begin
				busy <= 1'b0;
			end else begin
				pin <= ~pin;
				edges_q <= edges_q - 9'h001;
				cnt_q <= hold_clks;
			end
		end
	end
endmodule

`default_nettype wire

// ---- verif/dual_timer_counter_bench.sv ----
// Self-checking bench for the dual timer/counter.
// Assumes the register port and timing described in dtc_pkg.
`default_nettype none

module dual_timer_counter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dtc_pkg::*;

	`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("mismatch at %0t: got %h expected %h", $time, g, e); \
	end end

	// ==========================================================
	// Signals and instances
	// ==========================================================
	logic clk_sys, rst_n, irq_pin, p0_out, p0_oe, pin0, f0, f1, x16, bt;
	logic s0_start, s1_start, s0_pin, s1_pin, s0_busy, s1_busy;
	logic [7:0] rd_data, v;
	dtc_bus_req_s req;
	int n_mismatch, check_count;
	// Tick tallies belong to the counting process alone
	int n_x16 = 0;
	int n_bit = 0;

	// Toggle drive overrides the event source on the shared pin
	assign pin0 = p0_oe ? p0_out : s0_pin;

	dtc_timer_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus_req(req), .rd_data(rd_data),
		.count_input_zero_in(pin0), .count_input_zero_out(p0_out),
		.count_input_zero_oe(p0_oe), .count_input_one(s1_pin),
		.ext_irq_zero_pin(irq_pin), .overflow_flag_zero(f0),
		.overflow_flag_one(f1), .baud_x16_tick(x16), .baud_bit_tick(bt));

	dtc_event_src src0_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.start(s0_start), .n_pulses(8'h05), .hold_clks(8'h0c),
		.pin(s0_pin), .busy(s0_busy));
	dtc_event_src src1_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.start(s1_start), .n_pulses(8'h03), .hold_clks(8'h0c),
		.pin(s1_pin), .busy(s1_busy));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		n_x16 <= n_x16 + int'(x16);
		n_bit <= n_bit + int'(bt);
	end

	// ==========================================================
	// Bus tasks
	// ==========================================================
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	// Counts gained over 60 clocks, i.e. ten machine cycles
	task automatic rate(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v0, v1;
		rd_reg(a, v0);
		repeat (58) @(posedge clk_sys);
		rd_reg(a, v1);
		`CHK(8'(v1 - v0), e)
	endtask

	task automatic baud(input logic [7:0] pc, input int e16, input int eb);
		int a16, ab;
		wr_reg(ADDR_POWER_CONTROL_REG, pc);
		repeat (30) @(posedge clk_sys);
		a16 = n_x16;
		ab = n_bit;
		repeat (192) @(posedge clk_sys);
		`CHK(n_x16 - a16, e16)
		`CHK(n_bit - ab, eb)
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		print_verdict();
	end

	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		n_mismatch = 0;
		check_count = 0;
		rst_n = 1'b0;
		irq_pin = 1'b0;
		s0_start = 1'b0;
		s1_start = 1'b0;
		req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset values, reserved mode bits, unmapped place
		rd_reg(ADDR_TIMER_MODE_CONTROL, v); `CHK(v, 8'h00)
		rd_reg(ADDR_POWER_CONTROL_REG, v); `CHK(v, 8'h00)
		rd_reg(8'h90, v); `CHK(v, 8'h00)
		@(posedge clk_sys); #1 `CHK(rd_data, 8'h00)
		`CHK({p0_oe, p0_out}, 2'b01)
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'hff);
		rd_reg(ADDR_TIMER_MODE_CONTROL, v); `CHK(v, 8'h3f)
		// Timer function, 16-bit, gate clear with gate pin low
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h01);
		wr_reg(ADDR_RUN, 8'h10);
		rate(ADDR_TL0, 8'h0a);
		// Gate set: pin low stops, pin high runs
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h09);
		rate(ADDR_TL0, 8'h00);
		// The gate pin crosses a synchroniser: let it settle first
		@(posedge clk_sys);
		irq_pin <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rate(ADDR_TL0, 8'h0a);
		// 16-bit overflow with pin toggle
		wr_reg(ADDR_RUN, 8'h00);
		wr_reg(ADDR_AUX, 8'h01);
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h01);
		wr_reg(ADDR_TL0, 8'hfe);
		wr_reg(ADDR_TH0, 8'hff);
		wr_reg(ADDR_RUN, 8'h10);
		repeat (20) @(posedge clk_sys);
		#1 `CHK({f0, f1, p0_oe, p0_out}, 4'b1010)
		rd_reg(ADDR_TH0, v); `CHK(v, 8'h00)
		rd_reg(ADDR_RUN, v); `CHK(v, 8'h30)
		wr_reg(ADDR_RUN, 8'h00);
		#1 `CHK(f0, 1'b0)
		// 13-bit mode: TL0 upper bits hold, TH0 gets the carry
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h00);
		wr_reg(ADDR_TL0, 8'hff);
		wr_reg(ADDR_TH0, 8'h00);
		wr_reg(ADDR_RUN, 8'h10);
		repeat (9) @(posedge clk_sys);
		wr_reg(ADDR_RUN, 8'h00);
		rd_reg(ADDR_TH0, v); `CHK(v, 8'h01)
		rd_reg(ADDR_TL0, v); `CHK(v[7:5], 3'h7)
		// 8-bit auto-reload
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h02);
		wr_reg(ADDR_TH0, 8'hf0);
		wr_reg(ADDR_TL0, 8'hfe);
		wr_reg(ADDR_RUN, 8'h10);
		repeat (30) @(posedge clk_sys);
		wr_reg(ADDR_RUN, 8'h00);
		rd_reg(ADDR_TL0, v); `CHK(v[7:4], 4'hf)
		rd_reg(ADDR_TH0, v); `CHK(v, 8'hf0)
		// Both timers as event counters, bursts in parallel
		wr_reg(ADDR_AUX, 8'h02);
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h15);
		wr_reg(ADDR_TL0, 8'h00);
		wr_reg(ADDR_TL1, 8'h00);
		wr_reg(ADDR_RUN, 8'h50);
		@(posedge clk_sys);
		s0_start <= 1'b1;
		s1_start <= 1'b1;
		@(posedge clk_sys);
		s0_start <= 1'b0;
		s1_start <= 1'b0;
		// Busy only shows after the edge that takes start
		@(posedge clk_sys);
		for (int i = 0; i < 400 && (s0_busy || s1_busy); i++) begin
			@(posedge clk_sys);
		end
		repeat (30) @(posedge clk_sys);
		rd_reg(ADDR_TL0, v); `CHK(v, 8'h05)
		rd_reg(ADDR_TL1, v); `CHK(v, 8'h03)
		rate(ADDR_TL0, 8'h00);
		// Split mode: TH0 under run1, timer 1 stopped
		wr_reg(ADDR_AUX, 8'h00);
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h33);
		wr_reg(ADDR_RUN, 8'h40);
		rate(ADDR_TH0, 8'h0a);
		rate(ADDR_TL0, 8'h00);
		rate(ADDR_TL1, 8'h00);
		// Timer 1 reload of minus one drives the baud ticks; the low
		// byte starts at the reload value so it overflows every machine cycle
		wr_reg(ADDR_TIMER_MODE_CONTROL, 8'h20);
		wr_reg(ADDR_TH1, 8'hff);
		wr_reg(ADDR_TL1, 8'hff);
		baud(8'h00, 16, 1);
		baud(8'h80, 32, 2);
		rd_reg(ADDR_POWER_CONTROL_REG, v); `CHK(v, 8'h80)
		`CHK(f1, 1'b1)
		// Reset in mid-run clears the doubling bit, mode and flags
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd_reg(ADDR_POWER_CONTROL_REG, v); `CHK(v, 8'h00)
		rd_reg(ADDR_TIMER_MODE_CONTROL, v); `CHK(v, 8'h00)
		`CHK({f0, f1, p0_oe, p0_out}, 4'b0001)
		print_verdict();
	end
endmodule

`default_nettype wire
